// ### lvdrx_params.svh
// constant definitions for the data receiver delay alignment controller
`ifndef LVDRX_PARAMS_SVH
`define LVDRX_PARAMS_SVH
`define LVDRX_A_CLKGATE 8'h02
`define LVDRX_A_EVEN    8'h03
`define LVDRX_A_EVST    8'h04
`define LVDRX_A_CFG     8'h10
`define LVDRX_A_SDL     8'h11
`define LVDRX_A_SDH     8'h12
`define LVDRX_A_STL     8'h13
`define LVDRX_A_STH     8'h14
`define LVDRX_A_ASL     8'h19
`define LVDRX_A_ASH     8'h1A
`define LVDRX_A_ATL     8'h1B
`define LVDRX_A_ATH     8'h1C
`define LVDRX_A_STAT    8'h21
`define LVDRX_B_ON      0
`define LVDRX_B_RELOCK  1
`define LVDRX_B_FLAGCLR 2
`define LVDRX_B_GATE    1
`define LVDRX_B_LOCKEV  0
`define LVDRX_B_LOSSEV  1
`define LVDRX_F_LO2     7:6
`define LVDRX_F_HI8     9:2
`define LVDRX_F_STL     7:4
`define LVDRX_F_WIN     3:0
`define LVDRX_F_STH     5:0
`define LVDRX_R_SDL     2'h3
`define LVDRX_R_SDH     8'h25
`define LVDRX_R_STL     4'h7
`define LVDRX_R_STH     6'h0A
`define LVDRX_R_WIN     4'h1
`define LVDRX_TAP_MAX   10'h180
`define LVDRX_TAP_ONE   10'h001
`define LVDRX_LOSS_LIM  3'h3
`define LVDRX_PD_PERIOD 3'h7
`endif

// ### lvdrx_pkg.sv
// types shared by the data receiver delay alignment controller
`default_nettype none
package lvdrx_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SEARCH = 2'h1,
    ST_TRACK  = 2'h3,
    ST_LOST   = 2'h2
  } lvdrx_state_e;
  typedef logic [9:0] lvdrx_tap_t;
  typedef struct packed {
    logic pre;
    logic late_sample_clock;
  } lvdrx_pd_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lvdrx_req_s;
  typedef struct packed {
    logic       on;
    logic       relock;
    logic       clkGate;
    logic       lockEn;
    logic       lossEn;
    logic       arm;
    logic [1:0] sdl;
    logic [7:0] sdh;
    logic [3:0] stl;
    logic [3:0] win;
    logic [5:0] sth;
  } lvdrx_cfg_s;
endpackage
`default_nettype wire

// ### lvdrx_sync2.sv
// two-flop level synchroniser
`default_nettype none
module lvdrx_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  assign q = sync_q;
  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### lvdrx_link_pd.sv
// phase detector sampling on the incoming data clock domain
`include "lvdrx_params.svh"
`default_nettype none
module lvdrx_link_pd (
  input  wire logic                 dciClk,
  input  wire logic                 rst,
  input  wire logic                 preSample,
  input  wire logic                 postSample,
  output lvdrx_pkg::lvdrx_pd_s      pdCode,
  output logic                      pdToggle
);
  import lvdrx_pkg::*;
  logic      [1:0] rstSync_q;
  logic            linkRst;
  logic      [1:0] pdSync;
  logic      [2:0] cnt_q;
  logic      [2:0] cnt_d;
  lvdrx_pd_s       code_q;
  lvdrx_pd_s       code_d;
  logic            tog_q;
  logic            tog_d;
  assign linkRst  = rstSync_q[1];
  assign pdCode   = code_q;
  assign pdToggle = tog_q;
  // reset asserts at once, releases on this clock
  always_ff @(posedge dciClk or posedge rst)
  begin
    if (rst)
      rstSync_q <= 2'h3;
    else
      rstSync_q <= {rstSync_q[0], 1'b0};
  end
  // early/late captures are asynchronous to this clock
  lvdrx_sync2 #(.W(2)) u_pdSync (
    .clk (dciClk),
    .rst (linkRst),
    .d   ({preSample, postSample}),
    .q   (pdSync)
  );
  // one result per period; code held stable across the toggle crossing
  always_comb
  begin
    cnt_d  = cnt_q + 3'h1;
    code_d = code_q;
    tog_d  = tog_q;
    if (cnt_q == `LVDRX_PD_PERIOD)
    begin
      cnt_d  = 3'h0;
      code_d = pdSync;
      tog_d  = ~tog_q;
    end
  end
  always_ff @(posedge dciClk or posedge linkRst)
  begin
    if (linkRst)
    begin
      cnt_q  <= 3'h0;
      code_q <= '0;
      tog_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      code_q <= code_d;
      tog_q  <= tog_d;
    end
  end
endmodule
`default_nettype wire

// ### lvdrx_ctrl.sv
// data receiver delay alignment controller top with its register file
`include "lvdrx_params.svh"
`default_nettype none
module lvdrx_ctrl (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  dciClk,
  input  wire logic                  preSample,
  input  wire logic                  postSample,
  input  wire lvdrx_pkg::lvdrx_req_s regReq,
  output logic [7:0]                 regRdData,
  output lvdrx_pkg::lvdrx_tap_t      sampleTap,
  output lvdrx_pkg::lvdrx_tap_t      strobeTap,
  output logic [3:0]                 earlyLateWindow
);
  import lvdrx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // keep a programmed delay inside the delay line range
  function automatic lvdrx_tap_t clampTap(input lvdrx_tap_t t);
    clampTap = (t > `LVDRX_TAP_MAX) ? `LVDRX_TAP_MAX : t;
  endfunction

  // move the strobe delay toward the edge, saturating at both ends
  function automatic lvdrx_tap_t stepTap(input lvdrx_tap_t t, input lvdrx_pd_s p);
    if (!p.pre && !p.late_sample_clock)
      stepTap = (t == '0) ? t : t - `LVDRX_TAP_ONE;
    else
      stepTap = (t >= `LVDRX_TAP_MAX) ? `LVDRX_TAP_MAX : t + `LVDRX_TAP_ONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  lvdrx_cfg_s   cfg_q;
  lvdrx_cfg_s   cfg_d;
  logic         clrPulse;
  lvdrx_state_e state_q;
  lvdrx_state_e state_d;
  lvdrx_tap_t   smp_q;
  lvdrx_tap_t   smp_d;
  lvdrx_tap_t   stb_q;
  lvdrx_tap_t   stb_d;
  logic [2:0]   miss_q;
  logic [2:0]   miss_d;
  logic         goLost;
  logic         enterTrack;
  logic         lostFlag_q;
  logic         lostFlag_d;
  logic         lockEvt_q;
  logic         lockEvt_d;
  logic         lossEvt_q;
  logic         lossEvt_d;
  logic [7:0]   rd_q;
  logic [7:0]   rd_d;
  lvdrx_tap_t   progSample;
  lvdrx_tap_t   progStrobe;
  lvdrx_pd_s    linkCode;
  logic         linkTog;
  logic         togSync;
  logic         togDly_q;
  logic         pdNew;
  logic         inWin;

  assign regRdData       = rd_q;
  assign sampleTap       = smp_q;
  assign strobeTap       = stb_q;
  assign earlyLateWindow = cfg_q.win;
  assign progSample      = clampTap({cfg_q.sdh, cfg_q.sdl});
  assign progStrobe      = clampTap({cfg_q.sth, cfg_q.stl});

  ////////////////////////////////////////////////////////////////////////////
  // link side and crossing

  lvdrx_link_pd u_link (
    .dciClk     (dciClk),
    .rst        (rst),
    .preSample  (preSample),
    .postSample (postSample),
    .pdCode     (linkCode),
    .pdToggle   (linkTog)
  );

  // toggle crosses; the code word is held for a whole link period, so it
  // is settled well before the synchronised toggle edge reads it
  lvdrx_sync2 #(.W(1)) u_togSync (
    .clk (sys_clk),
    .rst (rst),
    .d   (linkTog),
    .q   (togSync)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      togDly_q <= 1'b0;
    else
      togDly_q <= togSync;
  end

  assign pdNew = togSync ^ togDly_q;
  assign inWin = !linkCode.pre && linkCode.late_sample_clock;  // rising edge inside window

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // write decode; flag clear arms on a 1 and fires on the next 0
  always_comb
  begin
    cfg_d    = cfg_q;
    clrPulse = 1'b0;
    if (regReq.wr)
    begin
      case (regReq.addr)
        `LVDRX_A_CFG:
        begin
          cfg_d.on     = regReq.wdata[`LVDRX_B_ON];
          cfg_d.relock = regReq.wdata[`LVDRX_B_RELOCK];
          cfg_d.arm    = regReq.wdata[`LVDRX_B_FLAGCLR];
          clrPulse     = cfg_q.arm & ~regReq.wdata[`LVDRX_B_FLAGCLR];
        end
        `LVDRX_A_SDL:     cfg_d.sdl = regReq.wdata[`LVDRX_F_LO2];
        `LVDRX_A_SDH:     cfg_d.sdh = regReq.wdata;
        `LVDRX_A_STL:
        begin
          cfg_d.stl = regReq.wdata[`LVDRX_F_STL];
          cfg_d.win = regReq.wdata[`LVDRX_F_WIN];
        end
        `LVDRX_A_STH:     cfg_d.sth = regReq.wdata[`LVDRX_F_STH];
        `LVDRX_A_CLKGATE: cfg_d.clkGate = regReq.wdata[`LVDRX_B_GATE];
        `LVDRX_A_EVEN:
        begin
          cfg_d.lockEn = regReq.wdata[`LVDRX_B_LOCKEV];
          cfg_d.lossEn = regReq.wdata[`LVDRX_B_LOSSEV];
        end
        default:          cfg_d = cfg_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cfg_q <= '{on: 1'b0, relock: 1'b1, clkGate: 1'b1, lockEn: 1'b0,
                 lossEn: 1'b0, arm: 1'b0, sdl: `LVDRX_R_SDL, sdh: `LVDRX_R_SDH,
                 stl: `LVDRX_R_STL, win: `LVDRX_R_WIN, sth: `LVDRX_R_STH};
    else
      cfg_q <= cfg_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // search and track state machine

  // search moves the strobe tap alone; from lock on both taps move together,
  // which keeps the two read-back delays equal while tracking
  always_comb
  begin
    state_d    = state_q;
    smp_d      = smp_q;
    stb_d      = stb_q;
    miss_d     = miss_q;
    goLost     = 1'b0;
    enterTrack = 1'b0;
    if (!cfg_q.on)
    begin
      state_d = ST_IDLE;
      smp_d   = progSample;
      stb_d   = progStrobe;
      miss_d  = 3'h0;
    end
    else if (cfg_q.clkGate)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          state_d = ST_SEARCH;
          smp_d   = progSample;
          stb_d   = progStrobe;
          miss_d  = 3'h0;
        end
        ST_SEARCH:
        begin
          if (pdNew && inWin)
          begin
            state_d    = ST_TRACK;
            smp_d      = stb_q;
            enterTrack = 1'b1;
          end
          else if (pdNew)
            stb_d = stepTap(stb_q, linkCode);
        end
        ST_TRACK:
        begin
          if (pdNew && inWin)
            miss_d = 3'h0;
          else if (pdNew)
          begin
            stb_d = stepTap(stb_q, linkCode);
            smp_d = stepTap(stb_q, linkCode);
            if (miss_q == `LVDRX_LOSS_LIM)
            begin
              goLost  = 1'b1;
              miss_d  = 3'h0;
              state_d = cfg_q.relock ? ST_SEARCH : ST_LOST;
            end
            else
              miss_d = miss_q + 3'h1;
          end
        end
        ST_LOST:
        begin
          if (cfg_q.relock)
            state_d = ST_SEARCH;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      smp_q   <= '0;
      stb_q   <= '0;
      miss_q  <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      smp_q   <= smp_d;
      stb_q   <= stb_d;
      miss_q  <= miss_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and events

  // a set arriving with its clear wins; the event is seen one cycle later
  always_comb
  begin
    lostFlag_d = goLost | (lostFlag_q & ~clrPulse);
    lockEvt_d  = (enterTrack & cfg_q.lockEn)
               | (lockEvt_q & cfg_q.lockEn & cfg_d.lockEn);
    lossEvt_d  = (goLost & cfg_q.lossEn)
               | (lossEvt_q & cfg_q.lossEn & cfg_d.lossEn);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lostFlag_q <= 1'b0;
      lockEvt_q  <= 1'b0;
      lossEvt_q  <= 1'b0;
    end
    else
    begin
      lostFlag_q <= lostFlag_d;
      lockEvt_q  <= lockEvt_d;
      lossEvt_q  <= lossEvt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back

  // all read sources live on sys_clk, so a read never sees a torn value
  always_comb
  begin
    rd_d = rd_q;
    if (regReq.rd)
    begin
      case (regReq.addr)
        `LVDRX_A_CFG:     rd_d = {6'h00, cfg_q.relock, cfg_q.on};
        `LVDRX_A_SDL:     rd_d = {cfg_q.sdl, 6'h00};
        `LVDRX_A_SDH:     rd_d = cfg_q.sdh;
        `LVDRX_A_STL:     rd_d = {cfg_q.stl, cfg_q.win};
        `LVDRX_A_STH:     rd_d = {2'h0, cfg_q.sth};
        `LVDRX_A_CLKGATE: rd_d = {6'h00, cfg_q.clkGate, 1'b0};
        `LVDRX_A_EVST:    rd_d = {6'h00, lossEvt_q, lockEvt_q};
        `LVDRX_A_ASL:     rd_d = {smp_q[1:0], 6'h00};
        `LVDRX_A_ASH:     rd_d = smp_q[`LVDRX_F_HI8];
        `LVDRX_A_ATL:     rd_d = {stb_q[1:0], 6'h00};
        `LVDRX_A_ATH:     rd_d = stb_q[`LVDRX_F_HI8];
        `LVDRX_A_STAT:    rd_d = {4'h0, state_q == ST_TRACK, state_q == ST_SEARCH,
                                  lostFlag_q, state_q == ST_TRACK};
        default:          rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rd_q <= 8'h00;
    else
      rd_q <= rd_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cbSys @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seqEnable;
    $rose(cfg_q.on) && cfg_q.clkGate && state_q == ST_IDLE;
  endsequence

  sequence seqLoss;
    goLost && cfg_q.relock;
  endsequence

  AST_START_SEARCH: assert property (seqEnable |=> state_q == ST_SEARCH &&
    smp_q == $past(progSample) && stb_q == $past(progStrobe))
    else $error("enable did not start search from the start values");

  AST_DISABLED_TAPS: assert property (!cfg_q.on ##1 !cfg_q.on |->
    smp_q == $past(progSample) && stb_q == $past(progStrobe) && state_q == ST_IDLE)
    else $error("disabled taps do not follow programmed delays");

  AST_LOCK_EQUAL: assert property (state_q == ST_TRACK |-> smp_q == stb_q)
    else $error("sample and strobe taps differ while locked");

  AST_RELOCK: assert property (seqLoss |=> state_q == ST_SEARCH && lostFlag_q)
    else $error("auto relock did not restart search");

  AST_FLAG_CLEAR: assert property (clrPulse && !goLost |=> !lostFlag_q)
    else $error("flag clear sequence did not clear lost flag");

  AST_EVENT_CLEAR: assert property (regReq.wr && regReq.addr == `LVDRX_A_EVEN
    && !regReq.wdata[`LVDRX_B_LOCKEV] |=> ##1 !lockEvt_q)
    else $error("lock event not cleared by disabling it");

  AST_GATE_FREEZE: assert property (cfg_q.on && !cfg_q.clkGate |=>
    $stable(state_q) && $stable(stb_q) && $stable(smp_q))
    else $error("controller moved with its clock gated");

  AST_STATUS_READ: assert property (regReq.rd && regReq.addr == `LVDRX_A_STAT |=>
    rd_q[3:0] == {$past(state_q) == ST_TRACK, $past(state_q) == ST_SEARCH,
                  $past(lostFlag_q), $past(state_q) == ST_TRACK})
    else $error("status read does not match controller state");

  AST_TAP_READ: assert property (regReq.rd && regReq.addr == `LVDRX_A_ASH |=>
    rd_q == $past(smp_q[9:2]) ##1 ($past(regReq.rd) || rd_q == $past(rd_q)))
    else $error("actual delay read back wrong or unstable");

endmodule
`default_nettype wire

// ### lvdrx_host_model.sv
// behavioural far-side host: free-running data clock and early/late samples
`default_nettype none
module lvdrx_host_model (
  input  wire lvdrx_pkg::lvdrx_tap_t strobeTap,
  input  wire lvdrx_pkg::lvdrx_tap_t target,
  input  wire logic                  missAll,
  output logic                       dciClk,
  output logic                       preSample,
  output logic                       postSample
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////////
  // link clock runs free at 30 ns, phase unrelated to the converter clock
  initial
  begin
    dciClk = 1'b0;
    #7;
    forever #15 dciClk = ~dciClk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // strobe early gives 11, late gives 00, centred gives 01; missAll forces a miss
  initial
  begin
    preSample  = 1'b0;
    postSample = 1'b0;
  end
  always @(negedge dciClk)
  begin
    if (missAll)
      {preSample, postSample} <= 2'b11;
    else if (strobeTap < target)
      {preSample, postSample} <= 2'b11;
    else if (strobeTap > target)
      {preSample, postSample} <= 2'b00;
    else
      {preSample, postSample} <= 2'b01;
  end
endmodule
`default_nettype wire

// ### lvdrx_ctrl_test.sv
// self-checking bench for the data receiver delay alignment controller
`default_nettype none
module lvdrx_ctrl_test;
  import lvdrx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  lvdrx_req_s  regReq  = '0;
  logic [7:0]  regRdData;
  lvdrx_tap_t  sampleTap;
  lvdrx_tap_t  strobeTap;
  lvdrx_tap_t  target  = 10'h0AA;
  logic [3:0]  earlyLateWindow;
  logic        dciClk;
  logic        preSample;
  logic        postSample;
  logic        missAll = 1'b0;
  logic [7:0]  rv;
  int          badCount  = 0;
  int          nCompared = 0;
  // reset-time readback table: address and expected byte
  logic [7:0]  tA [11] = '{8'h02, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                           8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h21};
  logic [7:0]  tE [11] = '{8'h02, 8'h02, 8'hC0, 8'h25, 8'h71, 8'h0A,
                           8'hC0, 8'h25, 8'hC0, 8'h29, 8'h00};
  ////////////////////////////////////////////////////////////////////////////////
  lvdrx_ctrl uut (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .dciClk          (dciClk),
    .preSample       (preSample),
    .postSample      (postSample),
    .regReq          (regReq),
    .regRdData       (regRdData),
    .sampleTap       (sampleTap),
    .strobeTap       (strobeTap),
    .earlyLateWindow (earlyLateWindow)
  );
  lvdrx_host_model host (
    .strobeTap  (strobeTap),
    .target     (target),
    .missAll    (missAll),
    .dciClk     (dciClk),
    .preSample  (preSample),
    .postSample (postSample)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz converter clock
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one compare for every value; bytes are zero-extended
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    nCompared++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // a request is one cycle wide; the write returns once its effect has reached the taps,
  // since the taps follow the configuration one edge later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    regReq <= '0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    regReq <= '0;
    #1 rv = regRdData;
  endtask
  // poll status until the masked bits match, bounded so a hang is reported
  task automatic waitStat(input logic [7:0] mask, input logic [7:0] val);
    for (int i = 0; i < 3000; i++)
    begin
      rd(8'h21);
      if ((rv & mask) === val)
        break;
    end
  endtask
  task automatic giveVerdict;
    $display("compared %0d values, %0d mismatches", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tResetValues;
    chk(earlyLateWindow, 10'h001, "window at reset");
    for (int i = 0; i < 11; i++)
    begin
      rd(tA[i]);
      chk(rv, tE[i], "reset register byte");
    end
    chk(sampleTap, 10'd151, "sample tap disabled");
    chk(strobeTap, 10'd167, "strobe tap disabled");
    rd(8'h05);
    chk(rv, 8'h00, "unmapped read");
    $display("test reset values done");
  endtask
  task automatic tDirect;
    wr(8'h11, 8'h40);
    wr(8'h12, 8'h32);
    chk(sampleTap, 10'd201, "direct sample tap");
    wr(8'h12, 8'hFF);
    chk(sampleTap, 10'd384, "clamped sample tap");
    rd(8'h12);
    chk(rv, 8'hFF, "stored high byte");
    wr(8'h12, 8'h25);
    wr(8'h11, 8'hC0);
    wr(8'h13, 8'h75);
    chk(earlyLateWindow, 10'h005, "window field");
    chk(strobeTap, 10'd167, "strobe low bits kept");
    $display("test direct taps done");
  endtask
  // strobe start stays at the default 167 as software is advised
  task automatic tLock;
    wr(8'h03, 8'h03);
    wr(8'h10, 8'h03);
    waitStat(8'h04, 8'h04);
    chk(rv[2], 1'b1, "search running");
    waitStat(8'h09, 8'h09);
    chk(rv, 8'h09, "locked and tracking");
    chk(strobeTap, 10'd170, "strobe tap locked");
    chk(sampleTap, 10'd170, "taps equal");
    rd(8'h1B);
    chk(rv, 8'h80, "strobe readback low");
    rd(8'h1C);
    chk(rv, 8'h2A, "strobe readback high");
    rd(8'h04);
    chk(rv[0], 1'b1, "lock event");
    $display("test lock done");
  endtask
  task automatic tLoss;
    @(posedge sys_clk);
    missAll <= 1'b1;
    waitStat(8'h02, 8'h02);
    chk(rv[1], 1'b1, "lost flag");
    rd(8'h04);
    chk(rv[1], 1'b1, "loss event");
    missAll <= 1'b0;
    waitStat(8'h09, 8'h09);
    chk(rv[0], 1'b1, "relocked");
    wr(8'h10, 8'h07);
    wr(8'h10, 8'h03);
    rd(8'h21);
    chk(rv, 8'h09, "flags cleared");
    wr(8'h03, 8'h00);
    rd(8'h04);
    chk(rv, 8'h00, "event status cleared");
    $display("test loss and relock done");
  endtask
  task automatic tGate;
    wr(8'h02, 8'h00);
    target <= 10'd180;
    repeat (60) @(posedge sys_clk);
    chk(strobeTap, 10'd170, "frozen while gated");
    wr(8'h02, 8'h02);
    for (int i = 0; i < 6000; i++)
    begin
      @(posedge sys_clk);
      if (sampleTap === 10'd180 && strobeTap === 10'd180)
        break;
    end
    chk(strobeTap, 10'd180, "strobe after ungate");
    chk(sampleTap, 10'd180, "sample after ungate");
    $display("test clock gate done");
  endtask
  // without auto relock a loss parks the controller until relock is set again
  task automatic tNoRelock;
    wr(8'h10, 8'h05);
    wr(8'h10, 8'h01);
    rd(8'h21);
    chk(rv, 8'h09, "tracking with flags cleared");
    @(posedge sys_clk);
    missAll <= 1'b1;
    waitStat(8'h0F, 8'h02);
    chk(rv, 8'h02, "parked after loss");
    chk(strobeTap, 10'd184, "taps held while parked");
    missAll <= 1'b0;
    wr(8'h10, 8'h03);
    waitStat(8'h09, 8'h09);
    chk(strobeTap, 10'd180, "search resumed by relock");
    $display("test loss without relock done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; reset covers at least three link clock edges too
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    tResetValues();
    tDirect();
    tLock();
    tLoss();
    tGate();
    tNoRelock();
    giveVerdict();
  end
  // watchdog, well beyond the longest search from the top of the delay line
  initial
  begin
    #1000us;
    badCount++;
    $display("wrong value at %0t: run did not finish", $time);
    giveVerdict();
  end
endmodule
`default_nettype wire
